/* File: include/adcsq_pkg.sv */
// Constants and types shared by the conversion sequencer.
package adcsq_pkg;

    // Register indices as printed; byte address is four times the index.
    localparam logic [7:0] IDX_PORT_A_DATA      = 8'h05;
    localparam logic [7:0] IDX_INTERRUPT_CTRL   = 8'h0b;
    localparam logic [7:0] IDX_PERIPH_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_RESULT_HIGH      = 8'h1e;
    localparam logic [7:0] IDX_CONV_CTRL_0      = 8'h1f;
    localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
    localparam logic [7:0] IDX_PERIPH_IRQ_EN    = 8'h8c;
    localparam logic [7:0] IDX_RESULT_LOW       = 8'h9e;
    localparam logic [7:0] IDX_CONV_CTRL_1      = 8'h9f;

    // Reset values.
    localparam logic [7:0] RST_CONV_CTRL_0      = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL_1      = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIRECTION = 8'hff;
    localparam logic [7:0] RST_PERIPH_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_PERIPH_IRQ_EN    = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_CTRL   = 8'h00;
    localparam logic [7:0] RST_PORT_A_OUT       = 8'h00;

    // Field positions in converter_control_0.
    localparam int C0_CLOCK_FIELD_LSB = 6;
    localparam int C0_CHANNEL_LSB     = 3;
    localparam int C0_GO_BIT          = 2;
    localparam int C0_ENABLE_BIT      = 0;
    // Field positions in converter_control_1.
    localparam int C1_JUSTIFY_BIT     = 7;
    localparam int C1_HALVE_BIT       = 6;
    localparam int C1_PIN_CONFIG_LSB  = 0;
    // Flag and enable position in the peripheral flag and enable registers.
    localparam int IRQ_CONV_BIT       = 6;

    // Timing.
    localparam int CLK_PERIOD_NS      = 10;
    localparam int RC_TAD_NS          = 4000;
    localparam int RC_TAD_CYCLES      = (RC_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCY_OSC_PERIODS    = 4;
    localparam logic [15:0] TCY_CYCLES = 16'(TCY_OSC_PERIODS);
    localparam logic [3:0] CONV_TADS    = 4'h9;
    localparam logic [3:0] RECOVER_TADS = 4'h2;

    // Oscillator divider per {halve, clock field}.
    localparam logic [15:0] TAD_DIV_2  = 16'h0002;
    localparam logic [15:0] TAD_DIV_4  = 16'h0004;
    localparam logic [15:0] TAD_DIV_8  = 16'h0008;
    localparam logic [15:0] TAD_DIV_16 = 16'h0010;
    localparam logic [15:0] TAD_DIV_32 = 16'h0020;
    localparam logic [15:0] TAD_DIV_64 = 16'h0040;
    localparam logic [1:0]  CLOCK_FIELD_RC = 2'h3;

    // Compare mode that turns the trigger into a conversion start.
    localparam logic [3:0] COMPARE_MODE_SPECIAL = 4'hb;

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_OFF     = 5'h01,
        ST_ACQUIRE = 5'h02,
        ST_START   = 5'h04,
        ST_CONVERT = 5'h08,
        ST_RECOVER = 5'h10
    } adcsq_state_t;

endpackage

/* File: design/adcsq_top.sv */
// Conversion sequencer of a 10-bit successive-approximation converter with an AHB-Lite register slave.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module adcsq_top #(
    parameter int RESULT_BITS = 10
) (
    // Clock and reset.
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave.
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // Core status and capture/compare trigger.
    input  wire logic                   sleep_mode,
    input  wire logic [3:0]             compare_mode_field,
    input  wire logic                   special_trigger,
    output logic                        timer_clear,
    output logic                        wake_req,
    // Analog side.
    input  wire logic [RESULT_BITS-1:0] conv_value,
    output logic [2:0]                  input_channel_select,
    output logic                        sample_connect,
    output logic                        converter_powered,
    // Port A pins.
    input  wire logic [7:0]             port_a_in,
    output logic [7:0]                  port_a_out,
    output logic [7:0]                  port_a_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        adcsq_pkg::adcsq_state_t state;
        logic [15:0] cnt;
        logic [3:0]  tads;
        logic        go;
        logic        enable;
        logic [1:0]  clock_field;
        logic [2:0]  channel;
        logic        justify;
        logic        halve;
        logic [3:0]  pin_config;
        logic        done_flag;
        logic [3:0]  other_flags;
        logic        done_irq_en;
        logic [3:0]  other_irq_en;
        logic [7:0]  intctl;
        logic [7:0]  port_out;
        logic [7:0]  direction;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic [7:0]  pin_s3;
        logic [7:0]  pin_val;
        logic        powered_down;
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic [31:0] rdata;
        logic        timer_clear;
        logic        wake;
    } adcsq_regs_t;

    adcsq_regs_t q;
    adcsq_regs_t d;

    // Result pair has no reset so that it survives any reset.
    logic [7:0] result_high_q;
    logic [7:0] result_low_q;
    logic [7:0] result_high_d;
    logic [7:0] result_low_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Oscillator periods per bit period; RC uses its own fixed count.
    function automatic logic [15:0] tad_length(input logic halve, input logic [1:0] field);
        logic [15:0] len;
        len = 16'(adcsq_pkg::RC_TAD_CYCLES);
        case ({halve, field})
            3'b000: len = adcsq_pkg::TAD_DIV_2;
            3'b100: len = adcsq_pkg::TAD_DIV_4;
            3'b001: len = adcsq_pkg::TAD_DIV_8;
            3'b101: len = adcsq_pkg::TAD_DIV_16;
            3'b010: len = adcsq_pkg::TAD_DIV_32;
            3'b110: len = adcsq_pkg::TAD_DIV_64;
            default: len = 16'(adcsq_pkg::RC_TAD_CYCLES);
        endcase
        return len;
    endfunction

    // Pins 4..0 that the pin configuration makes analog or reference inputs.
    function automatic logic [4:0] analog_mask(input logic [3:0] cfg);
        logic [4:0] m;
        m = 5'h1f;
        case (cfg)
            4'h4, 4'h5: m = 5'h0b;
            4'h6, 4'h7: m = 5'h00;
            4'hd:       m = 5'h0f;
            4'he:       m = 5'h01;
            4'hf:       m = 5'h0d;
            default:    m = 5'h1f;
        endcase
        return m;
    endfunction

    logic        is_rc;
    logic [15:0] tad_len;
    logic [15:0] start_len;
    logic [15:0] limit;
    logic        seg_end;
    logic        rd_take;
    logic        wr_take;
    logic [7:0]  rd_idx;
    logic [7:0]  wb;
    logic        sw_go_set;
    logic        sw_go_clear;
    logic        trig_start;
    logic        start_req;
    logic [15:0] packed_result;

    // Bit period and first segment; a divide-by-two period is shorter than one
    // instruction cycle, so the first segment never drops below that cycle.
    always_comb begin
        is_rc     = (q.clock_field == adcsq_pkg::CLOCK_FIELD_RC);
        tad_len   = tad_length(q.halve, q.clock_field);
        if (is_rc || tad_len < adcsq_pkg::TCY_CYCLES) begin
            start_len = adcsq_pkg::TCY_CYCLES;
        end else begin
            start_len = tad_len;
        end
        limit   = (q.state == adcsq_pkg::ST_START) ? start_len : tad_len;
        seg_end = (q.cnt == limit - 16'h0001);
    end

    // Bus decode; only the word index matters, the byte lanes above bit 7 read zero.
    always_comb begin
        rd_take  = hsel && htrans[1] && hready && !hwrite;
        wr_take  = hsel && htrans[1] && hready && hwrite;
        rd_idx   = haddr[9:2];
        wb       = hwdata[7:0];
        sw_go_set   = q.wr_pend && (q.wr_idx == adcsq_pkg::IDX_CONV_CTRL_0) && wb[adcsq_pkg::C0_GO_BIT];
        sw_go_clear = q.wr_pend && (q.wr_idx == adcsq_pkg::IDX_CONV_CTRL_0) && !wb[adcsq_pkg::C0_GO_BIT];
        trig_start  = special_trigger && (compare_mode_field == adcsq_pkg::COMPARE_MODE_SPECIAL)
                      && q.enable;
        // The enable already stored is what counts, so enabling and starting at once is not honoured.
        start_req   = (sw_go_set && q.enable) || trig_start;
        if (q.justify) begin
            packed_result = 16'({6'h00, conv_value});
        end else begin
            packed_result = 16'({conv_value, 6'h00});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        d = q;
        result_high_d = result_high_q;
        result_low_d  = result_low_q;

        // Three-stage pin sampler; a change counts once stages two and three agree.
        d.pin_s1 = port_a_in;
        d.pin_s2 = q.pin_s1;
        d.pin_s3 = q.pin_s2;
        if (q.pin_s2 == q.pin_s3) begin
            d.pin_val = q.pin_s3;
        end

        // Register writes land in the data phase.
        d.wr_pend = wr_take;
        d.wr_idx  = haddr[9:2];
        if (q.wr_pend) begin
            case (q.wr_idx)
                adcsq_pkg::IDX_CONV_CTRL_0: begin
                    d.clock_field = wb[adcsq_pkg::C0_CLOCK_FIELD_LSB +: 2];
                    d.channel     = wb[adcsq_pkg::C0_CHANNEL_LSB +: 3];
                    d.enable      = wb[adcsq_pkg::C0_ENABLE_BIT];
                end
                adcsq_pkg::IDX_CONV_CTRL_1: begin
                    d.justify    = wb[adcsq_pkg::C1_JUSTIFY_BIT];
                    d.halve      = wb[adcsq_pkg::C1_HALVE_BIT];
                    d.pin_config = wb[adcsq_pkg::C1_PIN_CONFIG_LSB +: 4];
                end
                adcsq_pkg::IDX_PERIPH_IRQ_FLAGS: begin
                    d.done_flag   = wb[adcsq_pkg::IRQ_CONV_BIT];
                    d.other_flags = wb[3:0];
                end
                adcsq_pkg::IDX_PERIPH_IRQ_EN: begin
                    d.done_irq_en  = wb[adcsq_pkg::IRQ_CONV_BIT];
                    d.other_irq_en = wb[3:0];
                end
                adcsq_pkg::IDX_INTERRUPT_CTRL:   d.intctl    = wb;
                adcsq_pkg::IDX_PORT_A_DATA:      d.port_out  = wb;
                adcsq_pkg::IDX_PORT_A_DIRECTION: d.direction = wb;
                adcsq_pkg::IDX_RESULT_HIGH: begin
                    if (!q.enable) begin
                        result_high_d = wb;
                    end
                end
                adcsq_pkg::IDX_RESULT_LOW: begin
                    if (!q.enable) begin
                        result_low_d = wb;
                    end
                end
                default: ;
            endcase
        end

        // The capture/compare trigger clears the periodic timer whether or not it converts.
        d.timer_clear = special_trigger && (compare_mode_field == adcsq_pkg::COMPARE_MODE_SPECIAL);

        // Power-down latch ends when the core leaves Sleep.
        if (!sleep_mode) begin
            d.powered_down = 1'b0;
        end

        // Sequencer.
        d.cnt = seg_end ? 16'h0000 : q.cnt + 16'h0001;
        case (q.state)
            adcsq_pkg::ST_OFF: begin
                d.cnt  = 16'h0000;
                d.tads = 4'h0;
                d.go   = 1'b0;
                if (q.enable && !q.powered_down && !(q.powered_down && sleep_mode)) begin
                    d.state = adcsq_pkg::ST_ACQUIRE;
                end
            end
            adcsq_pkg::ST_ACQUIRE: begin
                d.cnt = 16'h0000;
                if (start_req) begin
                    d.go    = 1'b1;
                    d.state = adcsq_pkg::ST_START;
                end
            end
            adcsq_pkg::ST_START, adcsq_pkg::ST_CONVERT: begin
                if (sleep_mode && !is_rc) begin
                    // A clocked conversion cannot survive the core's clock stopping.
                    d.go           = 1'b0;
                    d.powered_down = 1'b1;
                    d.state        = adcsq_pkg::ST_OFF;
                end else if (sw_go_clear) begin
                    d.go    = 1'b0;
                    d.cnt   = 16'h0000;
                    d.tads  = 4'h0;
                    d.state = adcsq_pkg::ST_RECOVER;
                end else if (seg_end && q.state == adcsq_pkg::ST_START) begin
                    d.tads  = 4'h0;
                    d.state = adcsq_pkg::ST_CONVERT;
                end else if (seg_end) begin
                    d.tads = q.tads + 4'h1;
                    if (q.tads == adcsq_pkg::CONV_TADS - 4'h1) begin
                        // Completion: load result, clear go, raise the flag.
                        result_high_d = packed_result[15:8];
                        result_low_d  = packed_result[7:0];
                        d.go          = 1'b0;
                        d.tads        = 4'h0;
                        if (sleep_mode && !q.done_irq_en) begin
                            d.powered_down = 1'b1;
                            d.state        = adcsq_pkg::ST_OFF;
                        end else begin
                            d.state = adcsq_pkg::ST_RECOVER;
                        end
                    end
                end
            end
            adcsq_pkg::ST_RECOVER: begin
                if (seg_end) begin
                    d.tads = q.tads + 4'h1;
                    if (q.tads == adcsq_pkg::RECOVER_TADS - 4'h1) begin
                        d.tads  = 4'h0;
                        d.state = adcsq_pkg::ST_ACQUIRE;
                    end
                end
            end
            default: begin
                d.state = adcsq_pkg::ST_OFF;
            end
        endcase

        // Completion flag: the hardware set wins over a clear in the same cycle.
        if (q.state == adcsq_pkg::ST_CONVERT && seg_end && !sw_go_clear
            && !(sleep_mode && !is_rc) && q.tads == adcsq_pkg::CONV_TADS - 4'h1) begin
            d.done_flag = 1'b1;
        end

        // Switching the converter off aborts and idles the sequencer at once.
        if (!d.enable) begin
            d.state = adcsq_pkg::ST_OFF;
            d.go    = 1'b0;
        end

        d.wake = sleep_mode && d.done_flag && d.done_irq_en;

        // Read data is captured in the address phase and stands in the data phase.
        d.rdata = 32'h0000_0000;
        if (rd_take) begin
            case (rd_idx)
                adcsq_pkg::IDX_CONV_CTRL_0:
                    d.rdata[7:0] = {q.clock_field, q.channel, q.go, 1'b0, q.enable};
                adcsq_pkg::IDX_CONV_CTRL_1:
                    d.rdata[7:0] = {q.justify, q.halve, 2'b00, q.pin_config};
                adcsq_pkg::IDX_PERIPH_IRQ_FLAGS:
                    d.rdata[7:0] = {1'b0, q.done_flag, 2'b00, q.other_flags};
                adcsq_pkg::IDX_PERIPH_IRQ_EN:
                    d.rdata[7:0] = {1'b0, q.done_irq_en, 2'b00, q.other_irq_en};
                adcsq_pkg::IDX_INTERRUPT_CTRL:   d.rdata[7:0] = q.intctl;
                adcsq_pkg::IDX_PORT_A_DIRECTION: d.rdata[7:0] = q.direction;
                adcsq_pkg::IDX_RESULT_HIGH:      d.rdata[7:0] = result_high_q;
                adcsq_pkg::IDX_RESULT_LOW:       d.rdata[7:0] = result_low_q;
                adcsq_pkg::IDX_PORT_A_DATA:
                    d.rdata[7:0] = q.pin_val & ~{3'b000, analog_mask(q.pin_config)};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Reset restores every control bit and, through the zero pin config, makes pins 4..0 analog inputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q              <= '0;
            q.state        <= adcsq_pkg::ST_OFF;
            q.clock_field  <= adcsq_pkg::RST_CONV_CTRL_0[7:6];
            q.channel      <= adcsq_pkg::RST_CONV_CTRL_0[5:3];
            q.go           <= adcsq_pkg::RST_CONV_CTRL_0[2];
            q.enable       <= adcsq_pkg::RST_CONV_CTRL_0[0];
            q.justify      <= adcsq_pkg::RST_CONV_CTRL_1[7];
            q.halve        <= adcsq_pkg::RST_CONV_CTRL_1[6];
            q.pin_config   <= adcsq_pkg::RST_CONV_CTRL_1[3:0];
            q.done_flag    <= adcsq_pkg::RST_PERIPH_IRQ_FLAGS[6];
            q.other_flags  <= adcsq_pkg::RST_PERIPH_IRQ_FLAGS[3:0];
            q.done_irq_en  <= adcsq_pkg::RST_PERIPH_IRQ_EN[6];
            q.other_irq_en <= adcsq_pkg::RST_PERIPH_IRQ_EN[3:0];
            q.intctl       <= adcsq_pkg::RST_INTERRUPT_CTRL;
            q.port_out     <= adcsq_pkg::RST_PORT_A_OUT;
            q.direction    <= adcsq_pkg::RST_PORT_A_DIRECTION;
        end else begin
            q <= d;
        end
    end

    // Result pair keeps its contents across every reset.
    always_ff @(posedge hclk) begin
        result_high_q <= result_high_d;
        result_low_q  <= result_low_d;
    end

    // Ready and response are constant flops: the slave never waits or errors.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_comb begin
        hrdata               = q.rdata;
        timer_clear          = q.timer_clear;
        wake_req             = q.wake;
        input_channel_select = q.channel;
        sample_connect       = (q.state == adcsq_pkg::ST_ACQUIRE);
        converter_powered    = (q.state != adcsq_pkg::ST_OFF);
        port_a_out           = q.port_out;
        port_a_oe            = ~q.direction;
    end

endmodule

/* File: verif/adcsq_checker.sv */
// Port checker for the conversion sequencer, bound to its top module.
`timescale 1ns/10ps
module adcsq_checker (
    // Clock, reset and bus.
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Sequencer and pins.
    input wire logic        sleep_mode,
    input wire logic [3:0]  compare_mode_field,
    input wire logic        special_trigger,
    input wire logic        timer_clear,
    input wire logic        wake_req,
    input wire logic        sample_connect,
    input wire logic        converter_powered,
    input wire logic [7:0]  port_a_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////
    // The slave answers at once and never signals an error.
    okay_resp_a:
        assert property (hreadyout && !hresp) else $error("bus not okay");
    // Read data shows only in a read data phase, upper bits clear.
    read_idle_a:
        assert property (hrdata != 0 |-> $past(hsel && htrans[1] && hready && !hwrite)) else $error("stray data");
    read_upper_a:
        assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
    // The trigger clears the timer one cycle later, enabled or not.
    trig_clear_a:
        assert property (special_trigger && compare_mode_field == 4'hb |=> timer_clear) else $error("no clear");
    clear_cause_a:
        assert property (timer_clear |-> $past(special_trigger && compare_mode_field == 4'hb)) else $error("bad clear");
    // Leaving reset the converter is off and every pin is an input.
    reset_idle_a:
        assert property ($rose(hresetn) |-> !converter_powered && !sample_connect && port_a_oe == 8'h00)
        else $error("not idle after reset");
    // Once sampling stops, the start segment plus the conversion or recovery keep it off.
    quiet_gap_a:
        assert property ($fell(sample_connect) && converter_powered |=> !sample_connect [*8]) else $error("gap short");
    // A converter powered down in Sleep stays down until Sleep ends.
    sample_power_a:
        assert property (sleep_mode && !converter_powered |=> !converter_powered) else $error("woke in sleep");
    // Wake requests come only from Sleep.
    wake_sleep_a:
        assert property (wake_req |-> $past(sleep_mode)) else $error("wake outside sleep");
    cover property (timer_clear);
    cover property ($fell(sample_connect));
    cover property (wake_req);
endmodule
bind adcsq_top adcsq_checker adcsq_checker_inst (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .sleep_mode, .compare_mode_field, .special_trigger, .timer_clear, .wake_req,
    .sample_connect, .converter_powered, .port_a_oe);

/* File: verif/adcsq_far.sv */
// Far-side model: the analog level handed to the converter.
`timescale 1ns/10ps
module adcsq_far (
    // Channel and sampling state from the sequencer.
    input  wire logic [2:0] input_channel_select,
    input  wire logic       sample_connect,
    // Level seen by the converter.
    output logic      [9:0] conv_value
);
    ////////////////////////////////////////////////////////////
    // The level is held only while the capacitor is isolated; while sampling it is scrambled.
    always_comb conv_value = sample_connect ? ~{7'h55, input_channel_select} : {7'h55, input_channel_select};
endmodule

/* File: verif/adcsq_top_test.sv */
// Self-checking bench for the conversion sequencer.
`timescale 1ns/10ps
module adcsq_top_test;
    typedef struct {logic [7:0] i; logic w; logic [7:0] d; logic [7:0] e;} adcsq_row_t;
    localparam logic [9:0] V = 10'h2a9;
    logic        hclk, hresetn, hsel, hwrite, sleep_mode, special_trigger;
    logic        hreadyout, hresp, timer_clear, wake_req, sample_connect, converter_powered;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [3:0]  compare_mode_field;
    logic [9:0]  conv_value;
    logic [2:0]  chan;
    logic [7:0]  port_a_oe, pa_out, q, rh, rl;
    int          errors, cmp_count, n;
    adcsq_row_t  rows [18] = '{'{8'h1f,0,0,0}, '{8'h9f,0,0,0}, '{8'h85,0,0,8'hff}, '{8'h0c,0,0,0},
        '{8'h8c,0,0,0}, '{8'h0b,1,8'h5a,8'h5a}, '{8'h9f,1,8'hff,8'hcf}, '{8'h9f,1,8'h06,8'h06},
        '{8'h05,0,0,8'h9c}, '{8'h9f,1,0,0}, '{8'h05,1,8'h3c,8'h80}, '{8'h1e,1,8'ha5,8'ha5},
        '{8'h9e,1,8'h3c,8'h3c}, '{8'h40,1,8'h77,0}, '{8'h1f,1,8'h04,0}, '{8'h1f,1,8'h05,8'h01},
        '{8'h1e,1,8'h11,8'ha5}, '{8'h1f,1,0,0}};
    adcsq_top adcsq_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sleep_mode, .compare_mode_field, .special_trigger,
        .timer_clear, .wake_req, .conv_value, .input_channel_select(chan), .sample_connect, .converter_powered,
        .port_a_in(8'h9c), .port_a_out(pa_out), .port_a_oe);
    adcsq_far adcsq_far_inst (.input_channel_select(chan), .sample_connect, .conv_value);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic conclude;
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One single transfer; ready and read data are taken at the rising edge that ends each phase.
    task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, i, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata[7:0];
    endtask
    // Runs one conversion on channel 1 and checks its length, flags and layout.
    task automatic conv(input int k);
        int bit_conv_period;
        bit_conv_period = 2 << k;
        bus(8'h9f, 1, {k[0], k[0], 6'h0});
        bus(8'h1f, 1, {k[2:1], 6'h09});
        bus(8'h1f, 1, {k[2:1], 6'h0d});
        @(negedge hclk);
        n = 0;
        while (sample_connect) @(negedge hclk);
        while (!sample_connect) begin
            n++;
            @(negedge hclk);
        end
        chk(n, (bit_conv_period < 4 ? 4 : bit_conv_period) + 11 * bit_conv_period, "cycles");
        bus(8'h0c, 0, 0);
        chk(q, 8'h40, "flag");
        bus(8'h1f, 0, 0);
        chk(q, {k[2:1], 6'h09}, "go");
        rh = k[0] ? {6'h0, V[9:8]} : V[9:2];
        rl = k[0] ? V[7:0] : {V[1:0], 6'h0};
        bus(8'h1e, 0, 0);
        chk(q, rh, "high");
        bus(8'h9e, 0, 0);
        chk(q, rl, "low");
        bus(8'h0c, 1, 0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Watchdog well beyond the longest expected run.
    initial begin
        #400000;
        errors++;
        conclude;
    end
    initial begin
        {hresetn, hsel, hwrite, sleep_mode, special_trigger} = '0;
        {haddr, hwdata, htrans, compare_mode_field} = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[j]) begin
            bus(rows[j].i, rows[j].w, rows[j].d);
            if (rows[j].w) bus(rows[j].i, 0, 0);
            chk(q, rows[j].e, "reg");
        end
        chk(pa_out, 8'h3c, "port out");
        // Divided clocks run far faster here than software may use them; only timing, flags and layout are checked.
        for (int k = 0; k < 6; k++) conv(k);
        // Abort early in a slow conversion, then time the recovery.
        bus(8'h1f, 1, 8'h8d);
        bus(8'h1f, 1, 8'h89);
        @(negedge hclk);
        n = 0;
        while (!sample_connect) begin
            n++;
            @(negedge hclk);
        end
        chk(n, 128, "recover");
        bus(8'h0c, 0, 0);
        chk(q, 8'h00, "abort flag");
        bus(8'h1e, 0, 0);
        chk(q, rh, "abort high");
        // Special event trigger, first enabled, then disabled.
        compare_mode_field <= 4'hb;
        for (int e = 1; e >= 0; e--) begin
            bus(8'h1f, 1, {7'h44, e[0]});
            @(posedge hclk);
            special_trigger <= 1'b1;
            @(posedge hclk);
            special_trigger <= 1'b0;
            bus(8'h1f, 0, 0);
            chk(q, {5'h11, e[0], 1'b0, e[0]}, "trig go");
        end
        // Sleep with a divided clock aborts and powers down; enable stays set.
        bus(8'h1f, 1, 8'h89);
        bus(8'h1f, 1, 8'h8d);
        sleep_mode <= 1'b1;
        bus(8'h1f, 0, 0);
        chk(q, 8'h89, "sleep ctl");
        @(negedge hclk);
        chk(converter_powered, 1'b0, "sleep pwr");
        @(posedge hclk);
        sleep_mode <= 1'b0;
        // RC clock conversion in Sleep completes and wakes the core.
        bus(8'h8c, 1, 8'h40);
        bus(8'h1f, 1, 8'hc9);
        bus(8'h1f, 1, 8'hcd);
        sleep_mode <= 1'b1;
        while (!wake_req) @(negedge hclk);
        @(posedge hclk);
        sleep_mode <= 1'b0;
        bus(8'h1f, 0, 0);
        chk(q, 8'hc9, "rc go");
        // A reset in mid-run clears control but keeps the result pair.
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        bus(8'h9e, 0, 0);
        chk(q, rl, "kept low");
        bus(8'h1f, 0, 0);
        chk(q, 8'h00, "ctl reset");
        conclude;
    end
endmodule
